// >>> src/osdr_defines.svh
// constants for the dual serial command receiver
`ifndef OSDR_DEFINES_SVH
`define OSDR_DEFINES_SVH
`define OSDR_SLAVE_ADDR      7'h5D
`define OSDR_BYTE_BITS       4'h8
`define OSDR_LINK_LAST       3'h7
`define OSDR_CMD_TYPES       16
`define OSDR_NUM_SYNC        10
`define OSDR_IX_SCL          0
`define OSDR_IX_SDA          1
`define OSDR_IX_HSYNC        2
`define OSDR_IX_VSYNC        3
`define OSDR_IX_SEL          4
`define OSDR_IX_MRST_N       5
`define OSDR_IX_TEST         6
`define OSDR_IX_CE           7
`define OSDR_IX_HPOL         8
`define OSDR_IX_VPOL         9
`define OSDR_SYS_PERIOD_NS   10
`define OSDR_I2C_MAX_KHZ     400
`define OSDR_LINK_MAX_KHZ    1000
`define OSDR_SYNC_LATENCY    3
`define OSDR_I2C_HALF_CYC    ((1000000 / `OSDR_I2C_MAX_KHZ) / 2 / `OSDR_SYS_PERIOD_NS)
`define OSDR_LINK_BYTE_CYC   ((1000000 / `OSDR_LINK_MAX_KHZ) * 8 / `OSDR_SYS_PERIOD_NS)
`endif

// >>> src/osdr_pkg.sv
// types for the dual serial command receiver
package osdr_pkg;
	typedef enum logic [2:0] {
		st_idle    = 3'h0,
		st_addr    = 3'h1,
		st_ack     = 3'h2,
		st_data    = 3'h3,
		st_stretch = 3'h4,
		st_ignore  = 3'h5
	} osdr_i2c_state_t;
endpackage : osdr_pkg

// >>> src/osdr_receiver.sv
// dual serial command receiver: I2C slave, 3-wire link, retrace commit
`timescale 1ns/1ps
`include "osdr_defines.svh"
module osdr_receiver #(
	parameter int BYTE_W = 8
) (
	// system
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              master_reset_n,
	// mode straps
	input  wire logic              serial_select,
	input  wire logic              test_mode,
	// video sync and polarity
	input  wire logic              hsync,
	input  wire logic              vsync,
	input  wire logic              hsync_pol,
	input  wire logic              vsync_pol,
	// I2C open-drain pins
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	// 3-wire link
	input  wire logic              link_clk,
	input  wire logic              link_enable,
	input  wire logic              serial_data_input,
	// command interpreter
	input  wire logic              ram_data_next,
	output logic                   cmd_valid,
	output logic [BYTE_W-1:0]      cmd_data,
	output logic                   ram_commit,
	output logic [BYTE_W-1:0]      ram_data
);

	// the address compare and bit counters assume byte transfers
	if (BYTE_W != 8) begin : g_bad_width
		$error("BYTE_W must be 8");
	end
	// synchroniser delay must fit inside the shortest clock half and link byte
	if (`OSDR_I2C_HALF_CYC <= `OSDR_SYNC_LATENCY || `OSDR_LINK_BYTE_CYC <= 2 * `OSDR_SYNC_LATENCY) begin : g_bad_rate
		$error("system clock too slow for serial rates");
	end

	// pin synchronisers: meta stage is read only by the sync stage
	logic [`OSDR_NUM_SYNC-1:0] meta_ff;
	logic [`OSDR_NUM_SYNC-1:0] sync_ff;
	logic [`OSDR_NUM_SYNC-1:0] prev_ff;
	always_ff @(posedge clk)
	begin
		meta_ff <= {vsync_pol, hsync_pol, link_enable, test_mode, master_reset_n, serial_select, vsync, hsync, sda_i, scl_i};
		sync_ff <= meta_ff;
		prev_ff <= sync_ff;
	end

	// polarity-corrected sync level
	function automatic logic sync_active(input logic level, input logic pol);
		sync_active = ~(level ^ pol);
	endfunction : sync_active

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic sel_i2c;
	logic rst_int;
	logic retrace;
	assign scl_s     = sync_ff[`OSDR_IX_SCL];
	assign sda_s     = sync_ff[`OSDR_IX_SDA];
	assign scl_rise  = scl_s & ~prev_ff[`OSDR_IX_SCL];
	assign scl_fall  = ~scl_s & prev_ff[`OSDR_IX_SCL];
	assign start_det = scl_s & prev_ff[`OSDR_IX_SCL] & prev_ff[`OSDR_IX_SDA] & ~sda_s;
	assign stop_det  = scl_s & prev_ff[`OSDR_IX_SCL] & ~prev_ff[`OSDR_IX_SDA] & sda_s;
	assign sel_i2c   = sync_ff[`OSDR_IX_SEL];
	// pin reset is active low and folded into the synchronous reset
	assign rst_int   = reset | ~sync_ff[`OSDR_IX_MRST_N];
	// retrace starts on the active edge of hsync while vsync is inactive
	// polarity straps pass the same synchroniser, so a strap change never meets a stale level
	assign retrace   = sync_active(sync_ff[`OSDR_IX_HSYNC], sync_ff[`OSDR_IX_HPOL])
	                 & ~sync_active(prev_ff[`OSDR_IX_HSYNC], sync_ff[`OSDR_IX_HPOL])
	                 & ~sync_active(sync_ff[`OSDR_IX_VSYNC], sync_ff[`OSDR_IX_VPOL]);

	// link clear follows the system reset so the link toggle starts known
	logic link_clear_ff;
	always_ff @(posedge clk)
	begin
		link_clear_ff <= rst_int;
	end

	// 3-wire receiver on the shift clock; enable low clears it at once
	logic [2:0]        lbits_ff;
	logic [2:0]        nxt_lbits;
	logic [BYTE_W-1:0] lshift_ff;
	logic [BYTE_W-1:0] nxt_lshift;
	logic [BYTE_W-1:0] lhold_ff;
	logic [BYTE_W-1:0] nxt_lhold;
	logic              ltog_ff;
	logic              nxt_ltog;
	logic              lbyte_done;
	always_comb
	begin
		lbyte_done = (lbits_ff == `OSDR_LINK_LAST);
		nxt_lshift = {serial_data_input, lshift_ff[BYTE_W-1:1]};
		nxt_lbits  = lbits_ff + 3'h1;
		nxt_lhold  = lhold_ff;
		nxt_ltog   = ltog_ff;
		if (lbyte_done)
		begin
			nxt_lhold = nxt_lshift;
			nxt_ltog  = ~ltog_ff;
		end
	end
	always_ff @(posedge link_clk or negedge link_enable)
	begin
		if (!link_enable)
		begin
			lbits_ff  <= 3'h0;
			lshift_ff <= '0;
		end
		else
		begin
			lbits_ff  <= nxt_lbits;
			lshift_ff <= nxt_lshift;
		end
	end
	// hold register outlives the enable so a finished byte still crosses
	always_ff @(posedge link_clk or posedge link_clear_ff)
	begin
		if (link_clear_ff)
		begin
			lhold_ff <= '0;
			ltog_ff  <= 1'b0;
		end
		else
		begin
			lhold_ff <= nxt_lhold;
			ltog_ff  <= nxt_ltog;
		end
	end

	// byte toggle crossing into the system clock
	logic tog_meta_ff;
	logic tog_sync_ff;
	logic tog_seen_ff;
	logic nxt_tog_seen;
	logic link_byte;
	always_comb
	begin
		link_byte    = (tog_sync_ff ^ tog_seen_ff) & ~sel_i2c;
		nxt_tog_seen = tog_sync_ff;
	end
	always_ff @(posedge clk)
	begin
		tog_meta_ff <= ltog_ff;
		tog_sync_ff <= tog_meta_ff;
		if (rst_int)
			tog_seen_ff <= 1'b0;
		else
			tog_seen_ff <= nxt_tog_seen;
	end

	// I2C slave receiver state
	osdr_pkg::osdr_i2c_state_t state_ff;
	osdr_pkg::osdr_i2c_state_t nxt_state;
	logic [3:0]        bits_ff;
	logic [3:0]        nxt_bits;
	logic [BYTE_W-1:0] shift_ff;
	logic [BYTE_W-1:0] nxt_shift;
	logic              sda_oe_ff;
	logic              nxt_sda_oe;
	logic              scl_oe_ff;
	logic              nxt_scl_oe;
	logic              addr_ok;
	logic              i2c_byte;
	logic              pend_ff;
	assign addr_ok  = (shift_ff[BYTE_W-1:1] == `OSDR_SLAVE_ADDR)
	                & (~shift_ff[0] | sync_ff[`OSDR_IX_TEST]);
	assign i2c_byte = (state_ff == osdr_pkg::st_data) & scl_fall & (bits_ff == `OSDR_BYTE_BITS);
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_bits   = bits_ff;
		nxt_shift  = shift_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_scl_oe = scl_oe_ff;
		if (!sel_i2c)
		begin
			nxt_state  = osdr_pkg::st_idle;
			nxt_bits   = 4'h0;
			nxt_sda_oe = 1'b0;
			nxt_scl_oe = 1'b0;
		end
		else if (start_det)
		begin
			// a start inside a byte is a bus error: the partial byte is dropped
			nxt_state  = osdr_pkg::st_addr;
			nxt_bits   = 4'h0;
			nxt_shift  = '0;
			nxt_sda_oe = 1'b0;
		end
		else if (stop_det)
		begin
			nxt_state  = osdr_pkg::st_idle;
			nxt_bits   = 4'h0;
			nxt_shift  = '0;
			nxt_sda_oe = 1'b0;
		end
		else
		begin
			case (state_ff)
				osdr_pkg::st_addr, osdr_pkg::st_data:
				begin
					if (scl_rise)
					begin
						nxt_shift = {shift_ff[BYTE_W-2:0], sda_s};
						nxt_bits  = bits_ff + 4'h1;
					end
					else if (scl_fall && bits_ff == `OSDR_BYTE_BITS)
					begin
						nxt_bits = 4'h0;
						if (state_ff == osdr_pkg::st_data || addr_ok)
						begin
							nxt_state  = osdr_pkg::st_ack;
							nxt_sda_oe = 1'b1;
						end
						else
							nxt_state = osdr_pkg::st_ignore;
					end
				end
				osdr_pkg::st_ack:
				begin
					if (scl_fall)
					begin
						nxt_sda_oe = 1'b0;
						// a commit in this very cycle needs no hold
						if (pend_ff && !retrace)
						begin
							// scl is already low here, so holding it makes no glitch
							nxt_state  = osdr_pkg::st_stretch;
							nxt_scl_oe = 1'b1;
						end
						else
							nxt_state = osdr_pkg::st_data;
					end
				end
				osdr_pkg::st_stretch:
				begin
					if (retrace)
					begin
						nxt_state  = osdr_pkg::st_data;
						nxt_scl_oe = 1'b0;
					end
				end
				default:
				begin
					nxt_state = state_ff;
				end
			endcase
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			state_ff  <= osdr_pkg::st_idle;
			bits_ff   <= 4'h0;
			shift_ff  <= '0;
			sda_oe_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			bits_ff   <= nxt_bits;
			shift_ff  <= nxt_shift;
			sda_oe_ff <= nxt_sda_oe;
			scl_oe_ff <= nxt_scl_oe;
		end
	end

	// byte hand-off and retrace commit; a new byte wins over the commit clear
	logic              cmd_valid_ff;
	logic              nxt_cmd_valid;
	logic [BYTE_W-1:0] cmd_data_ff;
	logic [BYTE_W-1:0] nxt_cmd_data;
	logic              nxt_pend;
	logic [BYTE_W-1:0] pend_data_ff;
	logic [BYTE_W-1:0] nxt_pend_data;
	logic              ram_commit_ff;
	logic              nxt_ram_commit;
	logic [BYTE_W-1:0] ram_data_ff;
	logic [BYTE_W-1:0] nxt_ram_data;
	logic              any_byte;
	logic [BYTE_W-1:0] any_data;
	always_comb
	begin
		any_byte       = i2c_byte | link_byte;
		any_data       = i2c_byte ? shift_ff : lhold_ff;
		nxt_cmd_valid  = any_byte;
		nxt_cmd_data   = any_byte ? any_data : cmd_data_ff;
		nxt_ram_commit = retrace & pend_ff;
		nxt_ram_data   = nxt_ram_commit ? pend_data_ff : ram_data_ff;
		nxt_pend       = pend_ff & ~retrace;
		nxt_pend_data  = pend_data_ff;
		// the 3-wire link cannot stall: a second RAM byte before retrace replaces the first
		if (any_byte && ram_data_next)
		begin
			nxt_pend      = 1'b1;
			nxt_pend_data = any_data;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			cmd_valid_ff  <= 1'b0;
			cmd_data_ff   <= '0;
			pend_ff       <= 1'b0;
			pend_data_ff  <= '0;
			ram_commit_ff <= 1'b0;
			ram_data_ff   <= '0;
		end
		else
		begin
			cmd_valid_ff  <= nxt_cmd_valid;
			cmd_data_ff   <= nxt_cmd_data;
			pend_ff       <= nxt_pend;
			pend_data_ff  <= nxt_pend_data;
			ram_commit_ff <= nxt_ram_commit;
			ram_data_ff   <= nxt_ram_data;
		end
	end

	// open-drain pins only ever pull low
	logic drive_low_ff;
	always_ff @(posedge clk)
	begin
		drive_low_ff <= 1'b0;
	end

	assign scl_o      = drive_low_ff;
	assign sda_o      = drive_low_ff;
	assign scl_oe     = scl_oe_ff;
	assign sda_oe     = sda_oe_ff;
	assign cmd_valid  = cmd_valid_ff;
	assign cmd_data   = cmd_data_ff;
	assign ram_commit = ram_commit_ff;
	assign ram_data   = ram_data_ff;

	// checks on the system clock
	sequence s_addr_hit;
		state_ff == osdr_pkg::st_addr && scl_fall && bits_ff == `OSDR_BYTE_BITS && addr_ok
			&& sel_i2c && !start_det && !stop_det;
	endsequence
	sequence s_stretch_start;
		state_ff == osdr_pkg::st_ack && scl_fall && pend_ff && !retrace && sel_i2c && !start_det && !stop_det;
	endsequence
	property p_deselect;
		@(posedge clk) disable iff (rst_int) !sel_i2c |=> state_ff == osdr_pkg::st_idle && !sda_oe_ff && !scl_oe_ff;
	endproperty
	a_deselect: assert property (p_deselect) else $error("I2C active while deselected");
	property p_byte_out;
		@(posedge clk) disable iff (rst_int) i2c_byte && sel_i2c && !start_det && !stop_det
			|=> cmd_valid_ff && cmd_data_ff == $past(shift_ff);
	endproperty
	a_byte_out: assert property (p_byte_out) else $error("byte not handed on");
	property p_sda_only_ack;
		@(posedge clk) disable iff (rst_int) sda_oe_ff |-> state_ff == osdr_pkg::st_ack;
	endproperty
	a_sda_only_ack: assert property (p_sda_only_ack) else $error("data line driven outside ack");
	property p_addr_ack;
		@(posedge clk) disable iff (rst_int) s_addr_hit |=> sda_oe_ff;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
	property p_stop;
		@(posedge clk) disable iff (rst_int) stop_det && !start_det |=> state_ff == osdr_pkg::st_idle;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not end transfer");
	property p_start;
		@(posedge clk) disable iff (rst_int) start_det && sel_i2c |=> state_ff == osdr_pkg::st_addr && bits_ff == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start did not restart receiver");
	property p_commit_in_retrace;
		@(posedge clk) disable iff (rst_int) ram_commit_ff |-> $past(retrace) && $past(pend_ff);
	endproperty
	a_commit_in_retrace: assert property (p_commit_in_retrace) else $error("commit outside retrace");
	property p_hold_clock;
		@(posedge clk) disable iff (rst_int) s_stretch_start
			|=> scl_oe_ff ##1 (scl_oe_ff || $past(retrace) || !$past(sel_i2c));
	endproperty
	a_hold_clock: assert property (p_hold_clock) else $error("clock not held for RAM byte");
	property p_release;
		@(posedge clk) disable iff (rst_int) state_ff == osdr_pkg::st_stretch && retrace && sel_i2c && !start_det
			|=> !scl_oe_ff && ram_commit_ff;
	endproperty
	a_release: assert property (p_release) else $error("clock not released with commit");
	property p_reset_hold;
		@(posedge clk) rst_int |=> state_ff == osdr_pkg::st_idle && !cmd_valid_ff && !pend_ff;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("receiver not held in reset");

	// check on the shift clock
	property p_link_byte;
		@(posedge link_clk) disable iff (!link_enable || link_clear_ff) lbits_ff == `OSDR_LINK_LAST
			|=> lbits_ff == 3'h0 && lhold_ff == {$past(serial_data_input), $past(lshift_ff[BYTE_W-1:1])} && ltog_ff != $past(ltog_ff);
	endproperty
	a_link_byte: assert property (p_link_byte) else $error("3-wire byte not completed");

endmodule : osdr_receiver

// >>> verif/osdr_host_model.sv
// host model: I2C master writer and 3-wire link sender
`timescale 1ns/1ps
module osdr_host_model (
	// system clock
	input  wire logic clk,
	// I2C wire levels and pull-downs
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_oe,
	output logic      sda_oe,
	// 3-wire link
	output logic      link_clk,
	output logic      link_enable,
	output logic      serial_data_input
);
	int stretch_cyc;
	// bus released, link clock parked high outside frames
	initial
	begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		link_clk = 1'b1;
		link_enable = 1'b0;
		serial_data_input = 1'b0;
	end
	// quarter of a 400 kHz bit, the fastest the receiver must take
	task automatic q_wait(input int n);
		repeat (n * 63) @(negedge clk);
	endtask : q_wait
	// release clock and wait; the receiver may stretch it
	task automatic scl_up();
		scl_oe = 1'b0;
		stretch_cyc = 0;
		while (scl !== 1'b1 && stretch_cyc < 20000)
		begin
			@(negedge clk);
			stretch_cyc++;
		end
	endtask : scl_up
	task automatic i2c_start();
		sda_oe = 1'b0;
		scl_up();
		q_wait(1);
		sda_oe = 1'b1;
		q_wait(1);
		scl_oe = 1'b1;
		q_wait(1);
	endtask : i2c_start
	// msb first; fewer than 8 bits leaves the byte cut short
	task automatic i2c_byte(input logic [7:0] b, input int nbits, output logic ack);
		ack = 1'b0;
		for (int i = 7; i > 7 - nbits; i--)
		begin
			sda_oe = ~b[i];
			q_wait(1);
			scl_up();
			q_wait(2);
			scl_oe = 1'b1;
			q_wait(1);
		end
		if (nbits == 8)
		begin
			sda_oe = 1'b0;
			q_wait(1);
			scl_up();
			q_wait(1);
			ack = ~sda;
			q_wait(1);
			scl_oe = 1'b1;
			q_wait(1);
		end
	endtask : i2c_byte
	task automatic i2c_stop();
		sda_oe = 1'b1;
		q_wait(1);
		scl_up();
		q_wait(1);
		sda_oe = 1'b0;
		q_wait(2);
	endtask : i2c_stop
	// bit i goes out on a falling edge, lsb first, 160 ns period
	task automatic link_send(input logic [7:0] b, input int nbits);
		#3;
		link_enable = 1'b1;
		for (int i = 0; i < nbits; i++)
		begin
			#80 link_clk = 1'b0;
			serial_data_input = b[i];
			#80 link_clk = 1'b1;
		end
	endtask : link_send
	// data line left undriven shows a changed level
	task automatic link_end();
		#80 link_enable = 1'b0;
		serial_data_input = ~serial_data_input;
	endtask : link_end
endmodule : osdr_host_model

// >>> verif/osdr_receiver_tb.sv
// self-checking bench for the dual serial command receiver
`timescale 1ns/1ps
`include "osdr_defines.svh"
module osdr_receiver_tb;
	logic       clk, reset, master_reset_n, serial_select, test_mode;
	logic       hsync, vsync, hsync_pol, vsync_pol, ram_data_next;
	logic       scl_o, scl_oe, sda_o, sda_oe, cmd_valid, ram_commit;
	logic       h_scl_oe, h_sda_oe, link_clk, link_enable, sdi;
	logic [7:0] cmd_data, ram_data;
	wire        scl, sda;
	int         n_mismatch, comparisons;
	logic [7:0] cmd_q[$], ram_q[$];
	// open-drain wires with pull-ups
	assign scl = ~((scl_oe & ~scl_o) | h_scl_oe);
	assign sda = ~((sda_oe & ~sda_o) | h_sda_oe);
	osdr_receiver dut_u (.clk(clk), .reset(reset), .master_reset_n(master_reset_n),
		.serial_select(serial_select), .test_mode(test_mode), .hsync(hsync), .vsync(vsync),
		.hsync_pol(hsync_pol), .vsync_pol(vsync_pol), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .link_clk(link_clk), .link_enable(link_enable),
		.serial_data_input(sdi), .ram_data_next(ram_data_next), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .ram_commit(ram_commit), .ram_data(ram_data));
	osdr_host_model host_u (.clk(clk), .scl(scl), .sda(sda), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe),
		.link_clk(link_clk), .link_enable(link_enable), .serial_data_input(sdi));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// every pulse must match the head of the reference queue
	always @(negedge clk)
	begin
		if (cmd_valid === 1'b1)
			check("cmd_data", cmd_data, cmd_q.size() ? cmd_q.pop_front() : 8'hXX);
		if (ram_commit === 1'b1)
			check("ram_data", ram_data, ram_q.size() ? ram_q.pop_front() : 8'hXX);
	end
	task automatic i2c_write(input logic [7:0] addr, input logic exp_ack, input int n);
		logic [7:0] b;
		logic       ack;
		host_u.i2c_start();
		host_u.i2c_byte(addr, 8, ack);
		check("addr_ack", 8'(ack), 8'(exp_ack));
		for (int k = 0; k < n; k++)
		begin
			b = 8'($urandom);
			if (exp_ack)
				cmd_q.push_back(b);
			host_u.i2c_byte(b, 8, ack);
			check("data_ack", 8'(ack), 8'(exp_ack));
		end
		host_u.i2c_stop();
		check("cmd_left", 8'(cmd_q.size()), 8'h00);
	endtask : i2c_write
	// a display RAM byte holds the bus until hsync turns active with vsync idle
	task automatic ram_write(input logic pol);
		logic [7:0] b;
		logic       ack;
		hsync_pol = pol;
		vsync_pol = pol;
		hsync = ~pol;
		vsync = ~pol;
		b = 8'($urandom);
		cmd_q.push_back(b);
		ram_q.push_back(b);
		host_u.i2c_start();
		host_u.i2c_byte({`OSDR_SLAVE_ADDR, 1'b0}, 8, ack);
		ram_data_next = 1'b1;
		host_u.i2c_byte(b, 8, ack);
		ram_data_next = 1'b0;
		fork
			host_u.i2c_stop();
			begin
				repeat (200) @(negedge clk);
				check("scl_held", 8'(scl_oe), 8'h01);
				vsync = pol;
				hsync = pol;
				repeat (50) @(negedge clk);
				check("ram_wait", 8'(ram_q.size()), 8'h01);
				hsync = ~pol;
				vsync = ~pol;
				repeat (50) @(negedge clk);
				hsync = pol;
				repeat (50) @(negedge clk);
				hsync = ~pol;
			end
		join
		check("ram_left", 8'(ram_q.size()), 8'h00);
	endtask : ram_write
	// lsb-first link bytes, a byte cut short by enable, then two back to back
	task automatic link_run();
		logic [7:0] b[3];
		foreach (b[k])
			b[k] = 8'($urandom);
		host_u.link_send(b[0], 5);
		host_u.link_end();
		cmd_q.push_back(b[1]);
		cmd_q.push_back(b[2]);
		host_u.link_send(b[1], 8);
		host_u.link_send(b[2], 8);
		host_u.link_end();
		repeat (20) @(negedge clk);
		check("link_left", 8'(cmd_q.size()), 8'h00);
	endtask : link_run
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// about 50k clocks of tests; the limit sits well past that
	initial
	begin
		#900_000;
		n_mismatch++;
		final_report();
	end
	initial
	begin
		logic ack;
		reset = 1'b1;
		master_reset_n = 1'b1;
		serial_select = 1'b1;
		test_mode = 1'b0;
		{hsync, vsync, hsync_pol, vsync_pol, ram_data_next} = 5'h0C;
		n_mismatch = 0;
		comparisons = 0;
		void'($urandom(55));
		repeat (5) @(negedge clk);
		reset = 1'b0;
		repeat (5) @(negedge clk);
		check("idle_out", 8'({scl_oe, sda_oe, cmd_valid, ram_commit}), 8'h00);
		i2c_write({`OSDR_SLAVE_ADDR, 1'b0}, 1'b1, 3);
		i2c_write(8'h3A, 1'b0, 1);
		for (int t = 0; t < 2; t++)
		begin
			test_mode = t[0];
			repeat (5) @(negedge clk);
			i2c_write({`OSDR_SLAVE_ADDR, 1'b1}, t[0], 1);
		end
		test_mode = 1'b0;
		// master reset mid-byte, then a stop inside a byte
		host_u.i2c_start();
		host_u.i2c_byte({`OSDR_SLAVE_ADDR, 1'b0}, 8, ack);
		host_u.i2c_byte(8'hA5, 4, ack);
		master_reset_n = 1'b0;
		repeat (6) @(negedge clk);
		master_reset_n = 1'b1;
		check("mrst_out", 8'({scl_oe, sda_oe}), 8'h00);
		host_u.i2c_stop();
		host_u.i2c_start();
		host_u.i2c_byte({`OSDR_SLAVE_ADDR, 1'b0}, 8, ack);
		host_u.i2c_byte(8'h5A, 3, ack);
		host_u.i2c_stop();
		i2c_write({`OSDR_SLAVE_ADDR, 1'b0}, 1'b1, 1);
		serial_select = 1'b0;
		repeat (5) @(negedge clk);
		i2c_write({`OSDR_SLAVE_ADDR, 1'b0}, 1'b0, 1);
		link_run();
		serial_select = 1'b1;
		repeat (5) @(negedge clk);
		ram_write(1'b0);
		ram_write(1'b1);
		final_report();
	end
endmodule : osdr_receiver_tb
